// [pst_cfg.svh]
// constants for the program sequencer and table read block
// assumes inclusion by bare name from the package and the design module
`ifndef PST_CFG_SVH
`define PST_CFG_SVH
`define PST_PHASES 4
`define PST_PC_W 12
`define PST_WORD_W 15
`define PST_STACK_DEPTH 8
`define PST_SST_CYCLES 1024
`define PST_VEC_RESET 12'h000
`define PST_VEC_EXT0 12'h004
`define PST_VEC_EXT1 12'h008
`define PST_VEC_TMR8 12'h00c
`define PST_VEC_TMR16 12'h010
`define PST_VEC_TBASE 12'h014
`define PST_VEC_RTC 12'h018
`define PST_VEC_ADC 12'h01c
`define PST_OFF_PCL 8'h06
`define PST_OFF_TBLPTR 8'h07
`define PST_OFF_THI 8'h08
`define PST_OFF_CTRL 8'h09
`define PST_OFF_STAT 8'h0a
`define PST_OFF_INSTR 8'h0b
`define PST_OFF_TDATA 8'h0c
`define PST_LAST_PAGE 4'hf
`endif

// [pst_pkg.sv]
// types for the program sequencer and table read block
// assumes pst_cfg.svh provides the numeric constants
`include "pst_cfg.svh"
package pst_pkg;
   // sequencer states, gray along wait, run and dummy steps; run to table flips both bits
   typedef enum logic [1:0] {
      PST_WAIT = 2'b00,
      PST_RUN = 2'b01,
      PST_DUMMY = 2'b11,
      PST_TABLE = 2'b10
   } pst_state_type;
   // operation presented for the current cycle
   typedef enum logic [2:0] {
      PST_OP_NONE = 3'h0,
      PST_OP_JUMP = 3'h1,
      PST_OP_CALL = 3'h2,
      PST_OP_RET = 3'h3,
      PST_OP_SKIP = 3'h4,
      PST_OP_TRDC = 3'h5,
      PST_OP_TRDL = 3'h6
   } pst_op_type;
   // instruction command word
   typedef struct packed {
      pst_op_type op;
      logic [11:0] target;
   } pst_cmd_type;
endpackage

// [pst_sequencer.sv]
// program sequencer: phases, counter, stack, vectors, table read, avalon slave
// assumes a synchronous program memory answering next cycle, irq pins asynchronous
//
// Contract
// RULE1: four system clocks per instruction cycle
// RULE2: fetch pipelined one cycle ahead of execute
// RULE3: counter changes cost one dummy cycle
// RULE4: twelve bit counter, increments per fetch
// RULE5: taken skip discards fetched word, adds two
// RULE6: reset clears counter to word zero
// RULE7: first external interrupt vectors to 004
// RULE8: second external interrupt vectors to 008
// RULE9: eight bit timer overflow vectors to 00c
// RULE10: sixteen bit timer overflow vectors to 010
// RULE11: time base interrupt vectors to 014
// RULE12: real time clock interrupt vectors to 018
// RULE13: conversion done interrupt vectors to 01c
// RULE14: low byte write jumps within page
// RULE15: jump, call, return load twelve bits
// RULE16: current page table uses counter high bits
// RULE17: last page table forces high bits ones
// RULE18: table word splits low byte, high latch
// RULE19: high latch read only, pointer read write
// RULE20: table read takes two instruction cycles
// RULE21: start-up timer holds 1024 clocks
// RULE22: eight level stack for calls, interrupts
// RULE23: full stack keeps interrupt pending
// RULE24: lowest vector wins simultaneous requests
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
`include "pst_cfg.svh"
module pst_sequencer (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // wake from halt restarts start-up timer
   input wire logic wake,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // program memory
   output logic [11:0] pm_addr,
   output logic pm_rd,
   input wire logic [14:0] pm_data,
   // interrupt requests, external pins and peripheral pulses
   input wire logic ext_irq_a_n,
   input wire logic ext_irq_b_n,
   input wire logic [4:0] periph_irq,
   // status
   output logic [11:0] pc_out,
   output logic [1:0] phase_out,
   output logic running
);
   // phase and state
   logic [1:0] phase_r;
   pst_pkg::pst_state_type state_r, state_nxt;
   logic [10:0] sst_r;
   logic [11:0] pc_r, pc_nxt;
   logic [14:0] ir_r;
   logic ir_valid_r;
   // stack storage
   logic [11:0] stack_r [0:`PST_STACK_DEPTH-1];
   logic [3:0] sp_r;
   // registers
   logic [7:0] tblptr_r, thi_r, tdata_r;
   logic [6:0] irq_en_r;
   logic [6:0] irq_pend_r;
   pst_pkg::pst_cmd_type cmd_r;
   logic cmd_valid_r, skip_cond_r;
   logic [11:0] table_addr_r;
   logic [31:0] rdata_r;
   logic ack_r;
   // low byte write waits here for the next instruction boundary
   logic pcl_pend_r;
   logic [7:0] pcl_val_r;
   // synchronisers for external pins
   logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r;

   // lowest set bit selector, used for irq and vector
   function automatic logic [2:0] lowest(input logic [6:0] v);
      lowest = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (v[i]) begin
            lowest = i[2:0];
         end
      end
   endfunction

   // byte write of a register from the bus word
   function automatic logic [7:0] lowbyte(input logic [31:0] d);
      lowbyte = d[7:0];
   endfunction

   // decode
   wire logic cyc_end = clk_en && (phase_r == 2'h3);            // [RULE1]
   wire logic [6:0] irq_src = {periph_irq, ~ext_s2_r[1], ~ext_s2_r[0]};
   wire logic [6:0] irq_live = irq_pend_r & irq_en_r;
   wire logic stack_full = (sp_r == 4'(`PST_STACK_DEPTH));
   wire logic irq_take = (|irq_live) && !stack_full && (state_r == pst_pkg::PST_RUN); // [RULE23]
   wire logic [2:0] irq_sel = lowest(irq_live);                 // [RULE24]
   wire logic [11:0] irq_vec = 12'(`PST_VEC_EXT0) + {7'h0, irq_sel, 2'h0}; // [RULE7] [RULE13]
   wire logic bus_req = (avs_read || avs_write) && !ack_r;
   wire logic pcl_hit = avs_write && ack_r && (avs_address == `PST_OFF_PCL);
   wire logic wr_pcl = pcl_pend_r;
   wire logic [11:0] pc_plus1 = pc_r + 12'h001;                 // [RULE4]
   wire logic [11:0] pc_skip = pc_r + 12'h002;
   wire logic [11:0] stack_top = stack_r[3'(sp_r - 4'h1)];
   wire logic [11:0] tbl_cur = {pc_r[11:8], tblptr_r};          // [RULE16]
   wire logic [11:0] tbl_last = {`PST_LAST_PAGE, tblptr_r};     // [RULE17]
   wire pst_pkg::pst_op_type op = cmd_valid_r ? cmd_r.op : pst_pkg::PST_OP_NONE;

   // phase counter cycles four clocks per instruction cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_r <= 2'h0;
      end else if (clk_en) begin
         phase_r <= phase_r + 2'h1;                             // [RULE1]
      end
   end

   // start-up timer, restarted on wake
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sst_r <= 11'h000;
      end else if (clk_en) begin
         if (wake) begin
            sst_r <= 11'h000;                                   // [RULE21]
         end else if (sst_r != 11'(`PST_SST_CYCLES)) begin
            sst_r <= sst_r + 11'h001;
         end
      end
   end

   // next state and counter, one decision per instruction cycle
   always_comb begin
      state_nxt = state_r;
      pc_nxt = pc_r;
      case (state_r)
         pst_pkg::PST_WAIT: begin
            if (sst_r == 11'(`PST_SST_CYCLES)) begin
               state_nxt = pst_pkg::PST_RUN;                    // [RULE21]
            end
         end
         pst_pkg::PST_RUN: begin
            if (irq_take) begin
               pc_nxt = irq_vec;                                // [RULE22]
               state_nxt = pst_pkg::PST_DUMMY;
            end else if (wr_pcl) begin
               pc_nxt = {pc_r[11:8], pcl_val_r};                // [RULE14]
               state_nxt = pst_pkg::PST_DUMMY;                  // [RULE3]
            end else begin
               case (op)
                  pst_pkg::PST_OP_JUMP, pst_pkg::PST_OP_CALL: begin
                     pc_nxt = cmd_r.target;                     // [RULE15]
                     state_nxt = pst_pkg::PST_DUMMY;            // [RULE3]
                  end
                  pst_pkg::PST_OP_RET: begin
                     pc_nxt = stack_top;                        // [RULE15]
                     state_nxt = pst_pkg::PST_DUMMY;
                  end
                  pst_pkg::PST_OP_SKIP: begin
                     pc_nxt = skip_cond_r ? pc_skip : pc_plus1; // [RULE5]
                     state_nxt = skip_cond_r ? pst_pkg::PST_DUMMY : pst_pkg::PST_RUN;
                  end
                  pst_pkg::PST_OP_TRDC, pst_pkg::PST_OP_TRDL: begin
                     state_nxt = pst_pkg::PST_TABLE;            // [RULE20]
                  end
                  default: begin
                     pc_nxt = pc_plus1;                         // [RULE4]
                  end
               endcase
            end
         end
         pst_pkg::PST_DUMMY: begin
            state_nxt = pst_pkg::PST_RUN;                       // [RULE3]
         end
         pst_pkg::PST_TABLE: begin
            pc_nxt = pc_plus1;
            state_nxt = pst_pkg::PST_RUN;                       // [RULE20]
         end
         default: begin
            state_nxt = pst_pkg::PST_WAIT;
         end
      endcase
   end

   // state, counter and fetch register; fetch runs a cycle ahead of execute
   always_ff @(posedge core_clk) begin
      if (rst || (clk_en && wake)) begin
         state_r <= pst_pkg::PST_WAIT;
         pc_r <= `PST_VEC_RESET;                                // [RULE6]
         ir_valid_r <= 1'b0;
      end else if (cyc_end) begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         // a fetched word counts only in a plain run cycle
         ir_valid_r <= (state_nxt == pst_pkg::PST_RUN) && (state_r == pst_pkg::PST_RUN); // [RULE2]
      end
   end

   // instruction word latch at phase 1 of fetch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ir_r <= 15'h0000;
      end else if (clk_en && phase_r == 2'h1) begin
         ir_r <= pm_data;                                       // [RULE2]
      end
   end

   // a bus write rarely lands on phase 3, so hold it until the cycle ends
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pcl_pend_r <= 1'b0;
         pcl_val_r <= 8'h00;
      end else if (clk_en) begin
         if (pcl_hit) begin
            pcl_pend_r <= 1'b1;                                 // [RULE14]
            pcl_val_r <= lowbyte(avs_writedata);
         end else if (cyc_end && state_r == pst_pkg::PST_RUN && !irq_take) begin
            pcl_pend_r <= 1'b0;
         end
      end
   end

   // stack push on call or interrupt, pop on returns
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sp_r <= 4'h0;
      end else if (cyc_end && state_r == pst_pkg::PST_RUN) begin
         if (irq_take || (op == pst_pkg::PST_OP_CALL && !wr_pcl)) begin
            // full stack on call loses the oldest entry, pointer holds
            if (!stack_full) begin
               sp_r <= sp_r + 4'h1;                             // [RULE22]
            end
         end else if (op == pst_pkg::PST_OP_RET && sp_r != 4'h0 && !wr_pcl) begin
            sp_r <= sp_r - 4'h1;                                // [RULE22]
         end
      end
   end

   // stack storage write, shifting when a call overflows
   always_ff @(posedge core_clk) begin
      if (cyc_end && state_r == pst_pkg::PST_RUN) begin
         if (irq_take) begin
            stack_r[3'(sp_r)] <= pc_r;                          // [RULE22]
         end else if (op == pst_pkg::PST_OP_CALL && !wr_pcl) begin
            if (stack_full) begin
               for (int i = 0; i < `PST_STACK_DEPTH - 1; i++) begin
                  stack_r[i] <= stack_r[i+1];
               end
               stack_r[`PST_STACK_DEPTH-1] <= pc_plus1;
            end else begin
               stack_r[3'(sp_r)] <= pc_plus1;                   // [RULE22]
            end
         end
      end
   end

   // pin synchronisers, then edge detect on the second stage
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ext_s1_r <= 2'h3;
         ext_s2_r <= 2'h3;
         ext_s3_r <= 2'h3;
      end else if (clk_en) begin
         ext_s1_r <= {ext_irq_b_n, ext_irq_a_n};
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // pending flags: set wins over acknowledge clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_pend_r <= 7'h00;
      end else if (clk_en) begin
         for (int i = 0; i < 7; i++) begin
            if (i < 2 ? (ext_s3_r[i] && !ext_s2_r[i]) : irq_src[i]) begin
               irq_pend_r[i] <= 1'b1;                           // [RULE7] [RULE8]
            end else if (cyc_end && irq_take && irq_sel == i[2:0]) begin
               irq_pend_r[i] <= 1'b0;                           // [RULE9] [RULE10] [RULE11] [RULE12]
            end
         end
      end
   end

   // table read capture during the second cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         table_addr_r <= 12'h000;
         thi_r <= 8'h00;
         tdata_r <= 8'h00;
      end else if (clk_en) begin
         if (state_r == pst_pkg::PST_RUN && phase_r == 2'h3) begin
            table_addr_r <= (op == pst_pkg::PST_OP_TRDL) ? tbl_last : tbl_cur;
         end
         if (state_r == pst_pkg::PST_TABLE && phase_r == 2'h3) begin
            tdata_r <= pm_data[7:0];                            // [RULE18]
            thi_r <= {1'b0, pm_data[14:8]};                     // [RULE18]
         end
      end
   end

   // command register: written by software, consumed at cycle end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd_r <= '0;
         cmd_valid_r <= 1'b0;
         skip_cond_r <= 1'b0;
      end else if (clk_en) begin
         if (avs_write && ack_r && avs_address == `PST_OFF_INSTR) begin
            cmd_r <= pst_pkg::pst_cmd_type'(avs_writedata[14:0]);
            skip_cond_r <= avs_writedata[15];
            cmd_valid_r <= 1'b1;
         end else if (cyc_end && state_r == pst_pkg::PST_RUN && !irq_take) begin
            cmd_valid_r <= 1'b0;
         end
      end
   end

   // software registers: pointer and enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tblptr_r <= 8'h00;
         irq_en_r <= 7'h00;
      end else if (clk_en && avs_write && ack_r) begin
         if (avs_address == `PST_OFF_TBLPTR) begin
            tblptr_r <= lowbyte(avs_writedata);                 // [RULE19]
         end
         if (avs_address == `PST_OFF_CTRL) begin
            irq_en_r <= avs_writedata[6:0];
         end
      end
   end

   // read mux; high latch has no write path
   wire logic [31:0] rd_mux =
      (avs_address == `PST_OFF_PCL) ? {24'h0, pc_r[7:0]} :
      (avs_address == `PST_OFF_TBLPTR) ? {24'h0, tblptr_r} :
      (avs_address == `PST_OFF_THI) ? {24'h0, thi_r} :          // [RULE19]
      (avs_address == `PST_OFF_CTRL) ? {25'h0, irq_en_r} :
      (avs_address == `PST_OFF_STAT) ? {10'h0, state_r, sp_r, irq_pend_r, 1'b0, pc_r[11:4]} :
      (avs_address == `PST_OFF_TDATA) ? {24'h0, tdata_r} : 32'h0;

   // bus answer one cycle after the request
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
      end else if (clk_en) begin
         ack_r <= bus_req;
         rdata_r <= rd_mux;
      end
   end

   // outputs
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = rdata_r;
   assign pm_addr = (state_r == pst_pkg::PST_TABLE) ? table_addr_r : pc_r;
   assign pm_rd = (state_r != pst_pkg::PST_WAIT);
   assign pc_out = pc_r;
   assign phase_out = phase_r;
   assign running = (state_r != pst_pkg::PST_WAIT);
endmodule

// [pst_sequencer_properties.sv]
// concurrent checks on the sequencer ports: phases, counter, start-up, bus
// assumes clk_en high whenever rst is asserted, one clock domain
`timescale 1ns/100ps
`include "pst_cfg.svh"
module pst_sequencer_properties (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic wake,
   // register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // sequencer status
   input wire logic pm_rd,
   input wire logic [11:0] pc_out,
   input wire logic [1:0] phase_out,
   input wire logic running
);
   localparam int SST = `PST_SST_CYCLES;
   logic [11:0] idle_r; // stopped cycles since reset or wake
   wire req = avs_read | avs_write;
   wire rd_done = avs_read & ~avs_waitrequest;
   wire unmapped = (avs_address < 8'h06) | (avs_address > 8'h0c);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // saturating count, so a hung start-up cannot wrap into a legal length
   always_ff @(posedge core_clk) begin
      if (rst || wake) begin
         idle_r <= 12'h000;
      end else if (clk_en && !running && idle_r != 12'hfff) begin
         idle_r <= idle_r + 12'h001;
      end
   end
   chk_phase_step: assert property (running && clk_en |=>
      !running || phase_out == $past(phase_out) + 2'h1) else $error("phase did not step");
   chk_pc_reset: assert property (disable iff (1'b0) rst && clk_en |=>
      pc_out == 12'h000) else $error("counter not cleared by reset");
   chk_idle_pc: assert property (!running && !wake |->
      pc_out == 12'h000) else $error("counter moved before start");
   chk_startup_len: assert property ($rose(running) |->
      idle_r >= SST - 4 && idle_r <= SST + 8) else $error("start-up length wrong");
   chk_fetch_on: assert property (running |-> pm_rd) else $error("no fetch");
   // a bus write may move the counter early, so it excuses the hold
   chk_pc_once: assert property (running && $changed(pc_out) |=>
      (!running || avs_write || $stable(pc_out)) [*3]) else $error("counter moved twice");
   chk_unmapped_zero: assert property (rd_done && unmapped |->
      avs_readdata == 32'h0) else $error("unmapped read not zero");
   chk_latch_width: assert property (rd_done && avs_address == `PST_OFF_THI |->
      avs_readdata[31:7] == 25'h0) else $error("latch read too wide");
   chk_wait_new: assert property ($rose(req) |-> avs_waitrequest)
      else $error("new request not stalled");
   chk_wait_done: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("request stalled too long");
endmodule
bind pst_sequencer pst_sequencer_properties u_chk (
   .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wake(wake),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pm_rd(pm_rd), .pc_out(pc_out), .phase_out(phase_out), .running(running)
);

// [pst_pm_model.sv]
// program memory model: 4096 words of 15 bits, answering the cycle after
// assumes the address holds while pm_rd is high
`timescale 1ns/100ps
module pst_pm_model (
   // clock
   input wire logic core_clk,
   // fetch side
   input wire logic [11:0] pm_addr,
   input wire logic pm_rd,
   output logic [14:0] pm_data
);
   // word content mixes the page bits in, so a wrong page shows up
   always_ff @(posedge core_clk) begin
      if (pm_rd) begin
         pm_data <= {pm_addr[11:5] ^ 7'h55, pm_addr[7:0] ^ 8'h3c};
      end else begin
         pm_data <= ~pm_data; // not read: no stale word survives
      end
   end
   initial pm_data = 15'h0;
endmodule

// [program_sequencer_table_read_tb.sv]
// self-checking bench for the program sequencer and table read block
// assumes pst_pm_model stands in for the program memory
`timescale 1ns/100ps
`include "pst_cfg.svh"
module program_sequencer_table_read_tb;
   // design inputs, all driven at time zero
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic wake = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic ext_irq_a_n = 1'b1;
   logic ext_irq_b_n = 1'b1;
   logic [4:0] periph_irq = 5'h00;
   // design outputs
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [11:0] pm_addr;
   logic pm_rd;
   logic [14:0] pm_data;
   logic [11:0] pc_out;
   logic [1:0] phase_out;
   logic running;
   // bench state
   localparam logic [11:0] VEC [7] = '{`PST_VEC_EXT0, `PST_VEC_EXT1, `PST_VEC_TMR8,
      `PST_VEC_TMR16, `PST_VEC_TBASE, `PST_VEC_RTC, `PST_VEC_ADC};
   int err_count = 0;
   int n_compared = 0;
   logic [31:0] exp_q [$]; // expected read data, oldest first
   logic [31:0] seed = 32'd91986;
   logic [31:0] r;
   logic [14:0] w;
   logic [11:0] t;
   int k;
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   pst_sequencer u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wake(wake),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .pm_rd(pm_rd),
      .pm_data(pm_data), .ext_irq_a_n(ext_irq_a_n), .ext_irq_b_n(ext_irq_b_n),
      .periph_irq(periph_irq), .pc_out(pc_out), .phase_out(phase_out), .running(running));
   pst_pm_model u_pm (.core_clk(core_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
      .pm_data(pm_data));
   // xorshift source for pointers and targets
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // word the memory model holds at an address
   function automatic logic [14:0] word(input logic [11:0] a);
      return {a[11:5] ^ 7'h55, a[7:0] ^ 8'h3c};
   endfunction
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic done;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      // waitrequest is settled mid-cycle; that value is what the next edge sees
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         done = (avs_waitrequest === 1'b0);
         @(posedge core_clk);
         if (done) break;
      end
      if (n == 50) begin
         err_count++;
         report_and_stop();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input pst_pkg::pst_op_type op, input logic [11:0] tg);
      bus(1'b1, `PST_OFF_INSTR, {17'h0, op, tg});
   endtask
   task automatic wait_pc(input logic [11:0] v);
      int n;
      for (n = 0; n < 400 && pc_out !== v; n++) @(negedge core_clk);
      check("pc_out", {20'h0, v}, {20'h0, pc_out});
   endtask
   // start-up length counted in clocks until running
   task automatic start_up();
      int n;
      for (n = 0; n < 2000 && running !== 1'b1; n++) @(posedge core_clk);
      check("startup", 32'h1, {31'h0, n >= `PST_SST_CYCLES - 4 && n <= `PST_SST_CYCLES + 8});
   endtask
   // bits 1:0 pull the external pins low, bits 6:2 pulse the peripherals
   task automatic fire(input logic [6:0] m);
      @(posedge core_clk);
      ext_irq_a_n <= ~m[0];
      ext_irq_b_n <= ~m[1];
      periph_irq <= m[6:2];
      @(posedge core_clk);
      periph_irq <= 5'h00;
      repeat (3) @(posedge core_clk);
      ext_irq_a_n <= 1'b1;
      ext_irq_b_n <= 1'b1;
   endtask
   // read results are matched against the oldest note, mid-cycle while they stand
   always @(negedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) check("read note", 32'h1, 32'h0);
         else check("readdata", exp_q.pop_front(), avs_readdata);
      end
   end
   initial begin
      #300us;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      start_up();
      wait_pc(12'h005);
      repeat (4) @(negedge core_clk);
      check("pc step", 32'h6, {20'h0, pc_out});
      $display("test start and step done");
      r = xs();
      bus(1'b1, `PST_OFF_TBLPTR, {24'h0, r[7:0]});
      rd(`PST_OFF_TBLPTR, {24'h0, r[7:0]});
      rd(8'h30, 32'h0);
      t = {4'h3, 1'b0, r[14:8]};
      cmd(pst_pkg::PST_OP_JUMP, t);
      wait_pc(t);
      bus(1'b1, `PST_OFF_PCL, 32'hc0);
      wait_pc(12'h3c0);
      $display("test registers and jumps done");
      for (k = 0; k < 2; k++) begin
         bus(1'b1, `PST_OFF_TBLPTR, {24'h0, r[23:16]});
         cmd(k ? pst_pkg::PST_OP_TRDL : pst_pkg::PST_OP_TRDC, 12'h000);
         repeat (24) @(posedge core_clk);
         w = word({k ? 4'hf : 4'h3, r[23:16]});
         rd(`PST_OFF_TDATA, {24'h0, w[7:0]});
         bus(1'b1, `PST_OFF_THI, 32'hff);
         rd(`PST_OFF_THI, {25'h0, w[14:8]});
      end
      $display("test table reads done");
      bus(1'b1, `PST_OFF_CTRL, 32'h7f);
      for (k = 0; k < 7; k++) begin
         fire(7'h01 << k);
         wait_pc(VEC[k]);
         cmd(pst_pkg::PST_OP_RET, 12'h000);
         repeat (16) @(posedge core_clk);
      end
      fire(7'h44);
      wait_pc(VEC[2]);
      wait_pc(VEC[6]);
      cmd(pst_pkg::PST_OP_RET, 12'h000);
      cmd(pst_pkg::PST_OP_RET, 12'h000);
      $display("test interrupts done");
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      repeat (2) @(posedge core_clk);
      check("pc after wake", 32'h0, {20'h0, pc_out});
      start_up();
      $display("test wake done");
      report_and_stop();
   end
endmodule
